// ### power_mode_defines.vh
/*
 Constants for the core power mode controller: register offset, bit
 positions, reset value and state codes. Assumes inclusion by bare name.
*/
`ifndef POWER_MODE_DEFINES_VH
`define POWER_MODE_DEFINES_VH
`define PMCS_ADDR 32'h0000FF80
`define PMCS_RESET 8'h00
`define BIT_FAST_OSC_DISABLE 1
`define BIT_IDLE_REQ 2
`define BIT_WAIT_BEFORE_PS 5
`define BIT_FAST_STABLE 6
`define BIT_SLOW_STABLE 7
`define WRITABLE_MASK 8'h26
`define ST_ACTIVE 2'h0
`define ST_IDLE 2'h1
`define ST_WAKING 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### core_power_mode_control.v
/*
 Power mode controller for the core domain with an AXI4-Lite register slave.
 Assumes all inputs are synchronous to sys_clk; power-off is signalled by
 a level from the supply monitor.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "power_mode_defines.vh"
module core_power_mode_control #(
    parameter ADDR_W = 32
) (
    input wire sys_clk,
    input wire rst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire wait_exec,
    input wire maskable_wake,
    input wire nmi_in,
    input wire debugger_interrupt,
    input wire int_ack,
    input wire power_off,
    input wire fast_clock_stable,
    input wire slow_clock_stable,
    output reg fast_clock_generator_en,
    output reg core_clock_run,
    output reg idle_mode,
    output reg wake_latched
);

////////////////////////////////////////////////////////////////////////////
// Binary state codes of the core domain power mode machine.
localparam [1:0] ST_ACTIVE = 2'h0;
localparam [1:0] ST_IDLE = 2'h1;
localparam [1:0] ST_WAKING = 2'h2;
// Edge-detected wake sources: the non-maskable and the debugger interrupt.
localparam WAKE_EDGE_W = 2;
localparam [7:0] RESET_BYTE = `PMCS_RESET;
localparam [ADDR_W-1:0] REG_ADDR = `PMCS_ADDR;

function addr_hit;
    input [ADDR_W-1:0] a;
    begin
        addr_hit = (a == REG_ADDR);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
reg [ADDR_W-1:0] awaddr_reg;
reg [ADDR_W-1:0] awaddr_next;
reg aw_held_reg;
reg aw_held_next;
reg [31:0] wdata_reg;
reg [31:0] wdata_next;
reg w_held_reg;
reg w_held_next;
reg w_en_reg;
reg w_en_next;
reg bvalid_next;
reg [1:0] bresp_next;
reg rvalid_next;
reg [31:0] rdata_next;
reg [1:0] rresp_next;
reg fast_osc_disable_reg;
reg fast_osc_disable_next;
reg idle_req_reg;
reg idle_req_next;
reg wait_before_ps_reg;
reg wait_before_ps_next;
reg wake_latched_next;
reg [1:0] state_reg;
reg [1:0] state_next;
reg idle_mode_next;
reg core_clock_run_next;
reg gen_en_next;
wire [WAKE_EDGE_W-1:0] wake_edge_in;
wire [WAKE_EDGE_W-1:0] wake_rise;
wire wake_event;
wire do_write;
wire wr_hit;
wire [7:0] status_byte;

////////////////////////////////////////////////////////////////////////////
// A held address or data beat blocks its own channel until the write lands.
assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
assign wr_hit = addr_hit(awaddr_reg) && w_en_reg;

assign status_byte = {slow_clock_stable, fast_clock_stable,
    wait_before_ps_reg, 2'b00, idle_req_reg, fast_osc_disable_reg,
    1'b0};

////////////////////////////////////////////////////////////////////////////
// The previous level starts at the idle level of the pins, so reset
// release never shows a false rising edge.
assign wake_edge_in = {debugger_interrupt, nmi_in};

genvar gi;
generate
    for (gi = 0; gi < WAKE_EDGE_W; gi = gi + 1) begin : g_wake_edge
        reg prev_reg;
        always @(posedge sys_clk) begin
            if (rst) begin
                prev_reg <= 1'b0;
            end else begin
                prev_reg <= wake_edge_in[gi];
            end
        end
        assign wake_rise[gi] = wake_edge_in[gi] && !prev_reg;
    end
endgenerate

assign wake_event = maskable_wake || (|wake_rise);

////////////////////////////////////////////////////////////////////////////
always @* begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    if (s_axi_awvalid && s_axi_awready) begin
        aw_held_next = 1'b1;
        awaddr_next = s_axi_awaddr;
    end
    if (do_write) begin
        aw_held_next = 1'b0;
    end
end

always @* begin
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    w_en_next = w_en_reg;
    if (s_axi_wvalid && s_axi_wready) begin
        w_held_next = 1'b1;
        wdata_next = s_axi_wdata;
        w_en_next = s_axi_wstrb[0];
    end
    if (do_write) begin
        w_held_next = 1'b0;
    end
end

always @* begin
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    if (do_write) begin
        bvalid_next = 1'b1;
        bresp_next = addr_hit(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
        bvalid_next = 1'b0;
    end
end

always @* begin
    rvalid_next = s_axi_rvalid;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
        rvalid_next = 1'b1;
        if (addr_hit(s_axi_araddr)) begin
            rdata_next = {24'h000000, status_byte};
            rresp_next = `RESP_OKAY;
        end else begin
            rdata_next = 32'h00000000;
            rresp_next = `RESP_SLVERR;
        end
    end else if (s_axi_rvalid && s_axi_rready) begin
        rvalid_next = 1'b0;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        aw_held_reg <= 1'b0;
        awaddr_reg <= {ADDR_W{1'b0}};
        w_held_reg <= 1'b0;
        wdata_reg <= 32'h00000000;
        w_en_reg <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_OKAY;
    end else begin
        aw_held_reg <= aw_held_next;
        awaddr_reg <= awaddr_next;
        w_held_reg <= w_held_next;
        wdata_reg <= wdata_next;
        w_en_reg <= w_en_next;
        s_axi_bvalid <= bvalid_next;
        s_axi_bresp <= bresp_next;
        s_axi_rvalid <= rvalid_next;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rresp_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// Hardware clear outranks a software write in the same cycle, so a wake
// that lands during a write is never lost.
always @* begin
    fast_osc_disable_next = fast_osc_disable_reg;
    idle_req_next = idle_req_reg;
    wait_before_ps_next = wait_before_ps_reg;
    if (do_write && wr_hit) begin
        fast_osc_disable_next = wdata_reg[`BIT_FAST_OSC_DISABLE];
        idle_req_next = wdata_reg[`BIT_IDLE_REQ];
        wait_before_ps_next = wdata_reg[`BIT_WAIT_BEFORE_PS];
    end
    if (wake_event) begin
        fast_osc_disable_next = 1'b0;
        idle_req_next = 1'b0;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        fast_osc_disable_reg <= RESET_BYTE[`BIT_FAST_OSC_DISABLE];
        idle_req_reg <= RESET_BYTE[`BIT_IDLE_REQ];
        wait_before_ps_reg <= RESET_BYTE[`BIT_WAIT_BEFORE_PS];
    end else begin
        fast_osc_disable_reg <= fast_osc_disable_next;
        idle_req_reg <= idle_req_next;
        wait_before_ps_reg <= wait_before_ps_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// A new wake wins over an acknowledge in the same cycle.
always @* begin
    wake_latched_next = wake_latched;
    if (wake_event) begin
        wake_latched_next = 1'b1;
    end else if (int_ack) begin
        wake_latched_next = 1'b0;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        wake_latched <= 1'b0;
    end else begin
        wake_latched <= wake_latched_next;
    end
end

////////////////////////////////////////////////////////////////////////////
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_ACTIVE: begin
            if (idle_req_reg && wait_before_ps_reg && wait_exec &&
                    slow_clock_stable && !wake_event) begin
                state_next = ST_IDLE;
            end
        end
        ST_IDLE: begin
            if (wake_event || wake_latched) begin
                state_next = ST_WAKING;
            end
        end
        ST_WAKING: begin
            if (fast_clock_stable) begin
                state_next = ST_ACTIVE;
            end
        end
        default: begin
            state_next = ST_ACTIVE;
        end
    endcase
end

always @(posedge sys_clk) begin
    if (rst) begin
        state_reg <= ST_ACTIVE;
    end else begin
        state_reg <= state_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// The disable bit only bites once Idle has really been entered; while
// waking the generator runs so that the stable flag can come up.
always @* begin
    idle_mode_next = (state_next != ST_ACTIVE);
    core_clock_run_next = (state_next == ST_ACTIVE);
    if (power_off) begin
        gen_en_next = 1'b0;
    end else if (state_next == ST_IDLE) begin
        gen_en_next = !fast_osc_disable_reg;
    end else begin
        gen_en_next = 1'b1;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        fast_clock_generator_en <= 1'b1;
        core_clock_run <= 1'b1;
        idle_mode <= 1'b0;
    end else begin
        fast_clock_generator_en <= gen_en_next;
        core_clock_run <= core_clock_run_next;
        idle_mode <= idle_mode_next;
    end
end

endmodule // core_power_mode_control

// ### power_mode_monitor.sv
/* Assertion checker bound to the power mode controller top.
 Assumes one clock domain, sys_clk, with rst synchronous. */
`timescale 1ns/100ps
module power_mode_monitor (
    input wire sys_clk, rst, s_axi_bvalid, s_axi_bready,
    input wire s_axi_rvalid, s_axi_rready, wait_exec, nmi_in, int_ack,
    input wire power_off, fast_clock_stable, slow_clock_stable,
    input wire fast_clock_generator_en, core_clock_run, idle_mode,
    input wire wake_latched
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    gen_off_a: assert property (power_off |=> !fast_clock_generator_en)
        else $error("fast clock on in power off");
    gen_active_a: assert property (core_clock_run && !power_off &&
        !$past(power_off) |-> fast_clock_generator_en) else $error("gen off");
    gen_fall_a: assert property ($fell(fast_clock_generator_en) |->
        idle_mode || $past(power_off)) else $error("gen stop outside idle");
    active_entry_a: assert property ($rose(core_clock_run) |->
        $past(fast_clock_stable) && $past(idle_mode)) else $error("run early");
    idle_entry_a: assert property ($rose(idle_mode) |->
        $past(slow_clock_stable) && $past(wait_exec)) else $error("bad idle");
    nmi_wake_a: assert property ($rose(nmi_in) |-> ##[0:2] wake_latched)
        else $error("nmi edge not latched");
    latch_hold_a: assert property ($fell(wake_latched) |-> $past(int_ack))
        else $error("wake latch lost");
    resp_done_a: assert property ((s_axi_bvalid && s_axi_bready) ||
        (s_axi_rvalid && s_axi_rready) |=> !s_axi_bvalid && !s_axi_rvalid)
        else $error("response repeated");
endmodule // power_mode_monitor
bind core_power_mode_control power_mode_monitor u_mon (.*);

// ### core_clock_partner.sv
/* Model of the core and the fast clock generator beside the controller.
 Assumes one clock; stab_dly sets how long the fast clock takes to settle. */
`timescale 1ns/100ps
module core_clock_partner (
    input wire sys_clk, rst, do_wait, wake_latched, core_clock_run,
    input wire fast_clock_generator_en,
    input wire [3:0] stab_dly,
    output reg fast_clock_stable, wait_exec, int_ack
);
    reg [3:0] cnt_reg;
    always @(posedge sys_clk) begin
        // A restarted clock is untrusted until it has run stab_dly + 1 cycles.
        if (rst || !fast_clock_generator_en) cnt_reg <= 4'h0;
        else if (cnt_reg != 4'hF) cnt_reg <= cnt_reg + 4'h1;
        fast_clock_stable <= !rst && fast_clock_generator_en &&
            cnt_reg >= stab_dly;
        wait_exec <= !rst && (do_wait || (wait_exec && !wake_latched));
        int_ack <= !rst && core_clock_run && wake_latched && !int_ack;
    end
endmodule // core_clock_partner

// ### core_power_mode_control_tb_top.sv
/* Bench for the power mode controller: register access, idle entry and
 every wake source. Needs the monitor and the core partner model. */
`timescale 1ns/100ps
`include "power_mode_defines.vh"
module core_power_mode_control_tb_top;
    reg sys_clk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    reg s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg maskable_wake = 1'h0, nmi_in = 1'h0, debugger_interrupt = 1'h0;
    reg do_wait = 1'h0, power_off = 1'h0, slow_clock_stable = 1'h1;
    reg ha, hw, hr, hb;
    reg [31:0] s_axi_awaddr = 32'h0, s_axi_araddr = 32'h0, s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hF, stab_dly = 4'h3;
    reg [7:0] r;
    reg [33:0] g, q[$];
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, wait_exec, int_ack, fast_clock_stable, idle_mode;
    wire fast_clock_generator_en, core_clock_run, wake_latched;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer error_cnt = 0, n_checks = 0, i, src;
    core_power_mode_control u_dut (.*);
    core_clock_partner u_core (.*);
    initial forever #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task chk(input [33:0] s, input [33:0] e);
        n_checks = n_checks + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task give_verdict;
        $display("errors=%0d checks=%0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One access at a time; the expected response is queued before it.
    task bus(input w, input [31:0] a, input [7:0] d, input [33:0] e);
        q.push_back(e);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        hb = 1'h0;
        while (!hb) begin
            @(negedge sys_clk);
            {ha, hw, hr} = {s_axi_awready, s_axi_wready, s_axi_arready};
            hb = w ? s_axi_bvalid : s_axi_rvalid;
            @(posedge sys_clk);
            if (ha) s_axi_awvalid <= 1'h0;
            if (hw) s_axi_wvalid <= 1'h0;
            if (hr) s_axi_arvalid <= 1'h0;
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        @(posedge sys_clk);
    endtask
    always @(negedge sys_clk) begin
        g = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
            chk(g, q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i = $urandom(58);
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (20) @(posedge sys_clk);
        bus(1'h0, `PMCS_ADDR, 8'h0, 34'hC0);
        for (i = 0; i < 4; i = i + 1) begin
            r = 8'($urandom);
            bus(1'h1, `PMCS_ADDR, r, 34'h0);
            bus(1'h0, `PMCS_ADDR, 8'h0, {26'h0, r & `WRITABLE_MASK | 8'hC0});
        end
        bus(1'h1, 32'hFF84, 8'hFF, {`RESP_SLVERR, 32'h0});
        bus(1'h0, 32'hFF84, 8'h0, {`RESP_SLVERR, 32'h0});
        power_off <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk(fast_clock_generator_en, 34'h0);
        power_off <= 1'h0;
        repeat (20) @(posedge sys_clk);
        for (src = 0; src < 3; src = src + 1) begin
            // Zone wait states are outside this block; the random settle
            // time stands in for a woken clock of unknown quality.
            stab_dly <= 4'($urandom);
            slow_clock_stable <= 1'h0;
            bus(1'h1, `PMCS_ADDR, 8'h26, 34'h0);
            do_wait <= 1'h1;
            @(posedge sys_clk);
            do_wait <= 1'h0;
            repeat (5) @(posedge sys_clk);
            chk(idle_mode, 34'h0);
            slow_clock_stable <= 1'h1;
            repeat (5) @(posedge sys_clk);
            chk({fast_clock_generator_en, idle_mode}, 34'h1);
            bus(1'h0, `PMCS_ADDR, 8'h0, 34'hA6);
            {debugger_interrupt, nmi_in, maskable_wake} <= 3'h1 << src;
            repeat (3) @(posedge sys_clk);
            {debugger_interrupt, nmi_in, maskable_wake} <= 3'h0;
            for (i = 0; i < 40 && !core_clock_run; i = i + 1)
                @(posedge sys_clk);
            chk(core_clock_run, 34'h1);
            repeat (3) @(posedge sys_clk);
            bus(1'h0, `PMCS_ADDR, 8'h0, 34'hE0);
            chk(wake_latched, 34'h0);
        end
        give_verdict;
    end
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
endmodule // core_power_mode_control_tb_top
